// ==== pkg/apm_pkg.sv ====
// Shared constants, layouts and state types of the ADC power-mode sequencer
package apm_pkg;

    // System clock period and wake-up time, both in nanoseconds
    localparam int CLK_NS = 20;
    localparam int WAKE_NS = 1000;
    // A least time: rounded up to whole clock cycles
    localparam int WAKE_CYCLES = (WAKE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [6:0] WAKE_LOAD = 7'(WAKE_CYCLES);
    localparam logic [6:0] WAKE_LAST = 7'h01;

    // Serial clock falling-edge counts within one frame
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] WRITE_BITS = 5'h0c;
    localparam logic [4:0] TRACK_EDGE = 5'h0e;

    localparam int RESULT_W = 12;
    localparam int FIFO_DEPTH = 16;

    // Control word as shifted in, first bit at the top
    typedef struct packed {
        logic write;
        logic [2:0] misc_hi;
        logic channel_sel_hi;
        logic channel_sel_lo;
        logic power_mode_hi;
        logic power_mode_lo;
        logic [3:0] misc_lo;
    } apm_ctrl_t;

    // Comes out of reset in full shutdown
    localparam apm_ctrl_t CTRL_RESET = 12'h020;

    // Output word, sent from the top bit down
    typedef struct packed {
        logic [1:0] lead;
        logic [1:0] channel;
        logic [RESULT_W-1:0] result;
    } apm_word_t;

    typedef enum logic [1:0] {MODE_NORMAL, MODE_FULL, MODE_AUTO} apm_mode_t;
    typedef enum logic [1:0] {PWR_ON, PWR_WAKE, PWR_OFF} apm_pwr_t;

    // Power field decode; the unused code falls to full shutdown
    function automatic apm_mode_t mode_of(input apm_ctrl_t c);
        apm_mode_t m;
        m = MODE_FULL;
        if (c.power_mode_hi && c.power_mode_lo) begin
            m = MODE_NORMAL;
        end else if (!c.power_mode_hi && c.power_mode_lo) begin
            m = MODE_AUTO;
        end
        return m;
    endfunction

endpackage

// ==== src/apm_fifo.sv ====
// Result FIFO with registered read data and a registered ready flag
`timescale 1ns/1ps
module apm_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    input wire logic out_ready_in,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
    localparam logic [AW:0] CNT_ZERO = '0;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic ready_q;
    logic valid_q;
    logic [WIDTH-1:0] data_q;

    wire push = in_valid_in & ready_q;
    // The output stage refills when it is empty or being taken and the memory holds an entry
    wire load = (cnt_q != CNT_ZERO) & (~valid_q | out_ready_in);

    assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

    always_ff @(posedge clock_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            ready_q <= 1'b1;
        end else begin
            wr_q <= push ? wr_q + 1'b1 : wr_q;
            rd_q <= load ? rd_q + 1'b1 : rd_q;
            cnt_q <= cnt_d;
            ready_q <= (cnt_d != CNT_FULL);
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            valid_q <= 1'b0;
            data_q <= '0;
        end else if (load) begin
            valid_q <= 1'b1;
            data_q <= mem_q[rd_q];
        end else if (out_ready_in) begin
            valid_q <= 1'b0;
        end
    end

    assign in_ready_out = ready_q;
    assign out_valid_out = valid_q;
    assign out_data_out = data_q;
endmodule

// ==== src/apm_power_seq.sv ====
// Serial frame handling and power-mode sequencing of a SAR converter
`timescale 1ns/1ps
module apm_power_seq (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic din_in,
    output logic dout_out,
    output logic dout_oe_out,
    input wire logic sample_valid_in,
    input wire logic [apm_pkg::RESULT_W-1:0] sample_data_in,
    output logic sample_ready_out,
    output apm_pkg::apm_ctrl_t ctrl_out,
    output logic powered_out,
    output logic tracking_out,
    output logic conv_valid_out,
    output logic frame_done_out,
    output logic frame_abort_out
);
    // Pin synchronisers; stage one feeds stage two only
    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_s3_q;
    logic sclk_s1_q;
    logic sclk_s2_q;
    logic sclk_s3_q;
    logic din_s1_q;
    logic din_s2_q;

    logic in_frame_q;
    logic [4:0] edge_cnt_q;
    logic [11:0] shift_in_q;
    logic [15:0] word_q;
    logic dout_q;
    logic dout_oe_q;
    apm_pkg::apm_ctrl_t ctrl_q;
    apm_pkg::apm_pwr_t pwr_q;
    apm_pkg::apm_pwr_t pwr_d;
    logic [6:0] wake_q;
    logic [6:0] wake_d;
    logic track_q;
    logic track_d;
    logic powered_q;
    logic conv_valid_q;
    logic done_q;
    logic abort_q;

    logic fifo_valid;
    logic [apm_pkg::RESULT_W-1:0] fifo_data;
    apm_pkg::apm_word_t word_new;

    // Edge detection runs on the second and third stages only
    wire cs_fall = cs_s3_q & ~cs_s2_q;
    wire cs_rise = ~cs_s3_q & cs_s2_q;
    wire full_frame = in_frame_q & (edge_cnt_q == apm_pkg::FRAME_BITS);
    wire sclk_fall = sclk_s3_q & ~sclk_s2_q & in_frame_q & ~cs_s2_q
                     & (edge_cnt_q != apm_pkg::FRAME_BITS);
    wire [4:0] edge_nxt = edge_cnt_q + 5'h01;
    wire take_bit = sclk_fall & (edge_cnt_q < apm_pkg::WRITE_BITS);

    wire apm_pkg::apm_ctrl_t rx_word = shift_in_q;
    wire apm_pkg::apm_mode_t mode_now = apm_pkg::mode_of(ctrl_q);
    wire apm_pkg::apm_mode_t mode_new = apm_pkg::mode_of(rx_word);
    wire commit = cs_rise & full_frame & rx_word.write;
    wire early_rise = cs_rise & in_frame_q & ~full_frame;
    wire wake_req_rx = rx_word.write & (mode_new == apm_pkg::MODE_NORMAL);
    wire sleeping = (pwr_q == apm_pkg::PWR_OFF);
    wire auto_asleep = sleeping & (mode_now == apm_pkg::MODE_AUTO);
    wire full_asleep = sleeping & (mode_now == apm_pkg::MODE_FULL);
    // Full shutdown keeps the output floating, wake frame included
    wire drive_ok = (mode_now != apm_pkg::MODE_FULL);

    assign word_new.lead = 2'h0;
    assign word_new.channel = {ctrl_q.channel_sel_hi, ctrl_q.channel_sel_lo};
    assign word_new.result = fifo_valid ? fifo_data : '0;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            // Serial clock idles high; a low reset value would fake an edge
            sclk_s1_q <= 1'b1;
            sclk_s2_q <= 1'b1;
            sclk_s3_q <= 1'b1;
            din_s1_q <= 1'b0;
            din_s2_q <= 1'b0;
        end else begin
            cs_s1_q <= cs_n_in;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            sclk_s1_q <= sclk_in;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            din_s1_q <= din_in;
            din_s2_q <= din_s1_q;
        end
    end

    // Results are taken one per frame start, so the FIFO backs up
    // into the sampling side whenever frames are slower than samples
    apm_fifo #(
        .WIDTH(apm_pkg::RESULT_W),
        .DEPTH(apm_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .in_valid_in(sample_valid_in),
        .in_data_in(sample_data_in),
        .in_ready_out(sample_ready_out),
        .out_ready_in(cs_fall),
        .out_valid_out(fifo_valid),
        .out_data_out(fifo_data)
    );

    // Frame bit counter and control word capture
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            in_frame_q <= 1'b0;
            edge_cnt_q <= '0;
            shift_in_q <= '0;
        end else if (cs_fall) begin
            in_frame_q <= 1'b1;
            edge_cnt_q <= '0;
        end else if (cs_rise) begin
            in_frame_q <= 1'b0;
        end else if (sclk_fall) begin
            edge_cnt_q <= edge_nxt;
            if (take_bit) begin
                shift_in_q <= {shift_in_q[10:0], din_s2_q};
            end
        end
    end

    // Serial output: first zero leaves at select fall, then one per edge
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            word_q <= '0;
            dout_q <= 1'b0;
            dout_oe_q <= 1'b0;
        end else if (cs_fall) begin
            word_q <= word_new;
            dout_q <= 1'b0;
            dout_oe_q <= drive_ok;
        end else if (cs_rise) begin
            dout_oe_q <= 1'b0;
        end else if (sclk_fall) begin
            word_q <= {word_q[14:0], 1'b0};
            dout_q <= word_q[14];
            if (edge_nxt == apm_pkg::FRAME_BITS) begin
                dout_oe_q <= 1'b0;
            end
        end
    end

    // Control register: only a complete write frame updates it
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_q <= apm_pkg::CTRL_RESET;
        end else if (commit) begin
            ctrl_q <= rx_word;
        end
    end

    // Power state; a sleep request waits for the end of its own frame
    always_comb begin
        pwr_d = pwr_q;
        wake_d = wake_q;
        unique case (pwr_q)
            apm_pkg::PWR_ON: begin
                pwr_d = apm_pkg::PWR_ON;
            end
            apm_pkg::PWR_WAKE: begin
                if (wake_q == apm_pkg::WAKE_LAST) begin
                    pwr_d = apm_pkg::PWR_ON;
                end else begin
                    wake_d = wake_q - 7'h01;
                end
            end
            apm_pkg::PWR_OFF: begin
                if (cs_fall && auto_asleep) begin
                    pwr_d = apm_pkg::PWR_WAKE;
                    wake_d = apm_pkg::WAKE_LOAD;
                end
            end
        endcase
        if (commit) begin
            if (mode_new != apm_pkg::MODE_NORMAL) begin
                pwr_d = apm_pkg::PWR_OFF;
            end else if (sleeping) begin
                pwr_d = apm_pkg::PWR_WAKE;
                wake_d = apm_pkg::WAKE_LOAD;
            end
        end
    end

    // Track-and-hold; the power field is known by the fourteenth edge
    always_comb begin
        track_d = track_q;
        if (cs_fall) begin
            track_d = auto_asleep;
        end else if (sclk_fall && edge_nxt == apm_pkg::TRACK_EDGE) begin
            track_d = ~(full_asleep & ~wake_req_rx);
        end else if (commit && mode_new != apm_pkg::MODE_NORMAL) begin
            track_d = 1'b0;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pwr_q <= apm_pkg::PWR_OFF;
            wake_q <= '0;
            track_q <= 1'b0;
            powered_q <= 1'b0;
        end else begin
            pwr_q <= pwr_d;
            wake_q <= wake_d;
            track_q <= track_d;
            powered_q <= (pwr_d == apm_pkg::PWR_ON);
        end
    end

    // A frame begun before wake-up completes carries no valid result
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            conv_valid_q <= 1'b0;
            done_q <= 1'b0;
            abort_q <= 1'b0;
        end else begin
            if (cs_fall) begin
                conv_valid_q <= (pwr_q == apm_pkg::PWR_ON) & fifo_valid;
            end
            done_q <= cs_rise & full_frame;
            abort_q <= early_rise;
        end
    end

    assign dout_out = dout_q;
    assign dout_oe_out = dout_oe_q;
    assign ctrl_out = ctrl_q;
    assign powered_out = powered_q;
    assign tracking_out = track_q;
    assign conv_valid_out = conv_valid_q;
    assign frame_done_out = done_q;
    assign frame_abort_out = abort_q;

    localparam int wake_len = apm_pkg::WAKE_CYCLES;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    a_write_loads_reg: assert property (
        commit |=> ctrl_q == $past(shift_in_q))
        else $error("write frame did not load control register");

    a_nowrite_keeps_reg: assert property (
        (cs_rise && !rx_word.write) |=> $stable(ctrl_q))
        else $error("control register changed without write bit");

    a_normal_stays_on: assert property (
        (pwr_q == apm_pkg::PWR_ON && mode_now == apm_pkg::MODE_NORMAL
        && !commit) |=> powered_q)
        else $error("normal mode lost power");

    a_track_at_edge: assert property (
        (sclk_fall && edge_nxt == apm_pkg::TRACK_EDGE && !sleeping)
        |=> track_q)
        else $error("no tracking after fourteenth edge");

    a_full_stays_down: assert property (
        (full_asleep && !cs_rise) |=> sleeping && !powered_q)
        else $error("full shutdown left without a write");

    a_wake_from_full: assert property (
        (commit && sleeping && mode_new == apm_pkg::MODE_NORMAL)
        |=> (pwr_q == apm_pkg::PWR_WAKE) ##[wake_len:wake_len] powered_q)
        else $error("wake from full shutdown not timed");

    a_full_no_drive: assert property (
        (cs_fall && mode_now == apm_pkg::MODE_FULL) |=> !dout_oe_q [*8])
        else $error("output driven in full shutdown frame");

    a_deselect_floats: assert property (
        (!in_frame_q) |-> !dout_oe_q)
        else $error("output driven while deselected");

    a_auto_sleeps_end: assert property (
        (commit && mode_new == apm_pkg::MODE_AUTO)
        |=> sleeping && !track_q)
        else $error("auto shutdown not entered at frame end");

    a_auto_wakes_fall: assert property (
        (cs_fall && auto_asleep)
        |=> pwr_q == apm_pkg::PWR_WAKE && track_q)
        else $error("auto shutdown did not wake on select fall");

    a_abort_keeps_reg: assert property (
        early_rise |=> $stable(ctrl_q) && !dout_oe_q && abort_q)
        else $error("aborted frame not handled");

    a_word_lead_zero: assert property (
        cs_fall |=> word_q[15:14] == 2'h0 && !dout_q)
        else $error("output word lacks leading zeros");

    a_early_invalid: assert property (
        (cs_fall && pwr_q != apm_pkg::PWR_ON) |=> !conv_valid_q)
        else $error("conversion before wake-up marked valid");

    a_wake_frame_tracks: assert property (
        (sclk_fall && edge_nxt == apm_pkg::TRACK_EDGE && wake_req_rx)
        |=> track_q)
        else $error("wake frame did not resume tracking");

    a_last_edge_float: assert property (
        (sclk_fall && edge_nxt == apm_pkg::FRAME_BITS) |=> !dout_oe_q)
        else $error("output still driven after sixteenth edge");

    a_done_on_full: assert property (
        (cs_rise && full_frame) |=> done_q && !abort_q)
        else $error("full frame end not reported");

    a_auto_sleep_holds: assert property (
        (auto_asleep && !cs_fall) |=> !track_q)
        else $error("tracking while asleep in auto shutdown");
endmodule

// ==== test/apm_host.sv ====
// Serial host model that runs frames against the converter's link pins
`timescale 1ns/1ps
module apm_host (
    input wire logic clock_in,
    input wire logic dout_in,
    input wire logic dout_oe_in,
    input wire logic tracking_in,
    input wire logic powered_in,
    output logic cs_n_out,
    output logic sclk_out,
    output logic din_out
);
    int since = 1000;
    logic [15:0] rd;
    logic oe_seen;
    logic trk_end;
    logic pwr_end;

    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b1;
        din_out = 1'b0;
    end

    always @(posedge clock_in) since <= since + 1;

    task automatic wait_n(input int n);
        repeat (n) @(negedge clock_in);
    endtask

    // Four system clocks make half of the 160 ns link period
    task automatic frame(input logic [15:0] w, input int n);
        while (since < 250) wait_n(1);
        cs_n_out = 1'b0;
        since = 0;
        oe_seen = 1'b0;
        rd = 16'h0000;
        wait_n(8);
        for (int k = 0; k < n; k++) begin
            din_out = w[15-k];
            wait_n(4);
            oe_seen = oe_seen | dout_oe_in;
            // An undriven line reads as the inverse of its last level
            rd[15-k] = dout_oe_in ? dout_in : ~dout_in;
            sclk_out = 1'b0;
            wait_n(4);
            sclk_out = 1'b1;
        end
        trk_end = tracking_in;
        pwr_end = powered_in;
        wait_n(4);
        cs_n_out = 1'b1;
        // Released line: show the inverse rather than a stale level
        din_out = ~din_out;
        wait_n(8);
    endtask
endmodule

// ==== test/tb_top.sv ====
// Self-checking bench for the power-mode sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
    $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic sample_valid_in = 1'b0;
    logic [11:0] sample_data_in = 12'h000;
    logic cs_n, sclk, din, dout, dout_oe, ready;
    apm_pkg::apm_ctrl_t ctrl;
    logic powered, tracking, conv_valid, done, abort;
    int err_total = 0;
    int checked = 0;
    int cycles = 0;
    int n;
    logic [31:0] seed;
    logic [11:0] exp_ctrl = 12'h020;
    logic [13:0] notes[$];
    logic [11:0] fq[$];
    logic [13:0] nt;
    logic [11:0] fw;

    always #10 clock_in = ~clock_in;

    apm_power_seq dut_u (.clock_in(clock_in), .rst_in(rst_in),
        .cs_n_in(cs_n), .sclk_in(sclk), .din_in(din), .dout_out(dout),
        .dout_oe_out(dout_oe), .sample_valid_in(sample_valid_in),
        .sample_data_in(sample_data_in), .sample_ready_out(ready),
        .ctrl_out(ctrl), .powered_out(powered), .tracking_out(tracking),
        .conv_valid_out(conv_valid), .frame_done_out(done),
        .frame_abort_out(abort));

    apm_host host_u (.clock_in(clock_in), .dout_in(dout),
        .dout_oe_in(dout_oe), .tracking_in(tracking), .powered_in(powered),
        .cs_n_out(cs_n), .sclk_out(sclk), .din_out(din));

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Every frame end pulse is matched against the oldest note
    always @(negedge clock_in) begin
        cycles++;
        if (cycles > 12000) begin
            err_total++;
            final_report();
        end else if ((done | abort) === 1'b1) begin
            if (notes.size() == 0) begin
                `CHK(1'b0, 1'b1)
            end else begin
                // Pop first: the macro reads its expected value twice
                nt = notes.pop_front();
                `CHK({done, abort, ctrl}, nt)
            end
        end
    end

    task automatic xfer(input logic [11:0] c, input int len);
        if (len == 16 && c[11]) exp_ctrl = c;
        notes.push_back({len == 16, len != 16, exp_ctrl});
        host_u.frame({c, 4'h0}, len);
    endtask

    task automatic fill(input int lim, output int cnt);
        logic [11:0] d;
        cnt = 0;
        while (ready === 1'b1 && cnt < lim) begin
            d = 12'($random(seed));
            sample_valid_in = 1'b1;
            sample_data_in = d;
            fq.push_back(d);
            cnt++;
            @(negedge clock_in);
        end
        sample_valid_in = 1'b0;
    endtask

    task automatic conv(input logic [11:0] c);
        logic [15:0] w;
        logic v;
        v = fq.size() > 0;
        w = {2'b00, exp_ctrl[7:6], v ? fq.pop_front() : 12'h000};
        xfer(c, 16);
        `CHK(host_u.rd, w)
        `CHK({host_u.oe_seen, host_u.trk_end, conv_valid}, {2'b11, v})
    endtask

    task automatic wait_c(input int k);
        repeat (k) @(negedge clock_in);
    endtask

    initial begin
        seed = 32'h3e5e6eb6;
        wait_c(16);
        rst_in = 1'b0;
        wait_c(4);
        `CHK({ctrl, powered, tracking}, {apm_pkg::CTRL_RESET, 2'b00})
        $display("reset test done");
        xfer(12'h7ff, 16);
        `CHK({host_u.oe_seen, powered}, 2'b00)
        xfer(12'hfff, 16);
        `CHK({host_u.oe_seen, powered}, 2'b00)
        wait_c(40);
        `CHK(powered, 1'b0)
        wait_c(15);
        `CHK(powered, 1'b1)
        $display("wake test done");
        fill(1, n);
        conv(12'hcb0);
        conv(12'hcb0);
        `CHK(powered, 1'b1)
        xfer(12'h8a0, 13);
        `CHK({host_u.trk_end, dout_oe, powered}, 3'b001)
        $display("normal test done");
        fill(20, n);
        `CHK({n inside {16, 17}, ready}, 2'b10)
        while (fq.size() > 0) conv(12'hcb0);
        conv(12'hcb0);
        $display("fifo test done");
        conv(12'h890);
        `CHK({host_u.pwr_end, powered, tracking}, 3'b100)
        fill(1, n);
        xfer(12'h000, 16);
        fw = fq.pop_front();
        `CHK({conv_valid, host_u.rd}, {3'b000, exp_ctrl[7:6], fw})
        `CHK(tracking, 1'b1)
        wait_c(60);
        `CHK(powered, 1'b1)
        conv(12'h890);
        `CHK({powered, tracking}, 2'b00)
        $display("auto test done");
        xfer(12'h000, 16);
        wait_c(60);
        xfer(12'h8a0, 16);
        `CHK(powered, 1'b0)
        xfer(12'h000, 16);
        wait_c(60);
        `CHK({host_u.oe_seen, powered, ctrl}, {2'b00, 12'h8a0})
        xfer(12'hfff, 16);
        wait_c(60);
        `CHK(powered, 1'b1)
        xfer(12'h800, 16);
        `CHK({powered, ctrl}, {1'b0, 12'h800})
        $display("shutdown test done");
        final_report();
    end
endmodule
